// ### logic/watchdog_timer.v
// Watchdog timer with fuse-selected safety levels and timed change sequence.
// Assumes an APB master on ref_clk; kick and fuses synchronous to ref_clk.
//
// Summary of operation
// - Counter advances on a 1 MHz oscillator tick
// - Kick instruction restarts counter from zero
// - Disable or chip reset clears the counter
// - Timeout while enabled issues chip reset
// - Select code picks 16384 shifted left by code
// - Fuses choose safety level and initial enable
// - Writing enable one always turns watchdog on
// - Enable bit written one enables, zero disables only while change bit is set
// - Clearing enable needs change bit reading one
// - Change bit self-clears four clocks after set
// - Level two can never be disabled
// - Levels one, two change period only in window
// - Control bits seven to five read zero
// - Timeout gives one-clock internal reset pulse
// - Watchdog reset flag, cleared by power-on or zero
// - Level two enable bit always reads one
`timescale 1ns/100ps
`include "watchdog_defines.vh"
module watchdog_timer #(
  parameter BASE_CYCLES = `WD_BASE_CYCLES,
  parameter OSC_DIV     = `WD_OSC_DIV
) (
  // Clock, reset, enable
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Core and fuses
  input  wire        kick_instruction,
  input  wire        chip_reset,
  input  wire        always_on_fuse,
  input  wire        compatibility_fuse,
  // Reset output
  output reg         dog_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  reg        rst_meta_n;
  reg        rst_sync_n;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safety level from fuses
  reg  [1:0] safety_level;

  always @* begin
    if (always_on_fuse) begin
      safety_level = `WD_LEVEL2;
    end else if (compatibility_fuse) begin
      safety_level = `WD_LEVEL0;
    end else begin
      safety_level = `WD_LEVEL1;
    end
  end

  wire level2 = (safety_level == `WD_LEVEL2);
  wire level0 = (safety_level == `WD_LEVEL0);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick, standing in for the separate 1 MHz watchdog clock
  localparam DIV_W = 8;
  localparam integer DIV_LAST_I = OSC_DIV - 1;
  localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];
  reg  [DIV_W-1:0] div_count;
  reg              osc_tick;

  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_count <= {DIV_W{1'b0}};
      osc_tick  <= 1'b0;
    end else if (clk_en) begin
      if (div_count == DIV_LAST) begin
        div_count <= {DIV_W{1'b0}};
        osc_tick  <= 1'b1;
      end else begin
        div_count <= div_count + {{(DIV_W-1){1'b0}}, 1'b1};
        osc_tick  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire       setup_phase  = psel && !penable;
  wire       access_phase = psel && penable;
  wire       hit_control  = (paddr == `WD_CONTROL_OFFSET);
  wire       hit_status   = (paddr == `WD_STATUS_OFFSET);
  wire       hit_any      = hit_control || hit_status;
  wire       wr_control   = access_phase && pwrite && hit_control && clk_en;
  wire       wr_status    = access_phase && pwrite && hit_status && clk_en;

  assign pready  = 1'b1;
  assign pslverr = access_phase && !hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // Control register state
  reg        watchdog_on_bit;
  reg        change_enable_bit;
  reg  [2:0] change_count;
  reg  [2:0] timeout_select;
  reg        dog_reset_flag;
  wire       expire;
  wire       soft_reset   = chip_reset || dog_reset_pulse;
  wire       wr_on        = pwdata[`WD_ON_BIT];
  wire       wr_change    = pwdata[`WD_CHANGE_BIT];
  wire [2:0] wr_select    = pwdata[`WD_SELECT_MSB:`WD_SELECT_LSB];
  wire       eff_on       = watchdog_on_bit || level2;
  wire       may_disable  = change_enable_bit && !level2;
  wire       may_select   = level0 || change_enable_bit;

  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      watchdog_on_bit <= 1'b0;
      timeout_select  <= `WD_SELECT_RESET;
    end else if (clk_en) begin
      if (soft_reset) begin
        watchdog_on_bit <= 1'b0;
        timeout_select  <= `WD_SELECT_RESET;
      end else if (wr_control) begin
        if (wr_on) begin
          watchdog_on_bit <= 1'b1;
        end else if (may_disable) begin
          watchdog_on_bit <= 1'b0;
        end
        if (may_select) begin
          timeout_select <= wr_select;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change window: set on write, cleared by hardware four clocks later
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      change_enable_bit <= 1'b0;
      change_count      <= `WD_CHANGE_COUNT_RESET;
    end else if (clk_en) begin
      if (soft_reset) begin
        change_enable_bit <= 1'b0;
        change_count      <= `WD_CHANGE_COUNT_RESET;
      end else if (wr_control && wr_change) begin
        change_enable_bit <= 1'b1;
        change_count      <= `WD_CHANGE_COUNT_RESET;
      end else if (change_enable_bit) begin
        if (change_count == `WD_CHANGE_CYCLES - 1) begin
          change_enable_bit <= 1'b0;
          change_count      <= `WD_CHANGE_COUNT_RESET;
        end else begin
          change_count <= change_count + 3'h1;
        end
      end else if (wr_control) begin
        change_enable_bit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Kick capture: held until the next oscillator tick so it meets the counter
  reg        kick_pending;

  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      kick_pending <= 1'b0;
    end else if (clk_en) begin
      if (kick_instruction) begin
        kick_pending <= 1'b1;
      end else if (osc_tick) begin
        kick_pending <= 1'b0;
      end
    end
  end

  wire counter_clear = soft_reset || kick_instruction || kick_pending;

  watchdog_counter #(
    .BASE_CYCLES    (BASE_CYCLES),
    .CNT_W          (22)
  ) u_counter (
    .ref_clk        (ref_clk),
    .rst_sync_n     (rst_sync_n),
    .clk_en         (clk_en),
    .tick           (osc_tick),
    .clear          (counter_clear),
    .enable         (eff_on),
    .timeout_select (timeout_select),
    .expire         (expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse and flag
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dog_reset_pulse <= 1'b0;
      dog_reset_flag  <= 1'b0;
    end else if (clk_en) begin
      dog_reset_pulse <= expire && !dog_reset_pulse;
      if (expire) begin
        dog_reset_flag <= 1'b1;
      end else if (wr_status && !pwdata[`WD_RESET_FLAG_BIT]) begin
        dog_reset_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle
  reg  [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h0000_0000;
    if (hit_control) begin
      next_prdata[`WD_SELECT_MSB:`WD_SELECT_LSB] = timeout_select;
      next_prdata[`WD_ON_BIT]                    = eff_on;
      next_prdata[`WD_CHANGE_BIT]                = change_enable_bit;
    end else if (hit_status) begin
      next_prdata[`WD_RESET_FLAG_BIT] = dog_reset_flag;
    end
  end

  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && setup_phase) begin
      prdata <= next_prdata;
    end
  end

endmodule // watchdog_timer

// ### logic/watchdog_defines.vh
// Constants for the watchdog with safety levels: register map, fields, timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

// Register byte offsets on APB
`define WD_CONTROL_OFFSET     12'h000
`define WD_STATUS_OFFSET      12'h004

// Control register fields
`define WD_SELECT_LSB         0
`define WD_SELECT_MSB         2
`define WD_ON_BIT             3
`define WD_CHANGE_BIT         4

// Status register fields
`define WD_RESET_FLAG_BIT     3

// Reset values
`define WD_SELECT_RESET       3'h0
`define WD_CHANGE_COUNT_RESET 3'h0

// Timing
`define WD_CLK_HZ             10000000
`define WD_OSC_HZ             1000000
`define WD_OSC_DIV            (`WD_CLK_HZ / `WD_OSC_HZ)
`define WD_BASE_CYCLES        16384
`define WD_CHANGE_CYCLES      4

// Safety levels
`define WD_LEVEL0             2'h0
`define WD_LEVEL1             2'h1
`define WD_LEVEL2             2'h2

`endif

// ### logic/watchdog_counter.v
// Watchdog period counter advanced by the oscillator tick.
// Assumes tick is one ref_clk cycle wide and clear/enable are synchronous.
`timescale 1ns/100ps
module watchdog_counter #(
  parameter BASE_CYCLES = 16384,
  parameter CNT_W       = 22
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst_sync_n,
  input  wire             clk_en,
  // Control
  input  wire             tick,
  input  wire             clear,
  input  wire             enable,
  input  wire [2:0]       timeout_select,
  // Result
  output reg              expire
);

  reg  [CNT_W-1:0] count;
  wire [CNT_W-1:0] base_cnt = BASE_CYCLES[CNT_W-1:0];
  wire [CNT_W-1:0] last_cnt = (base_cnt << timeout_select) - {{(CNT_W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count  <= {CNT_W{1'b0}};
      expire <= 1'b0;
    end else if (clk_en) begin
      expire <= 1'b0;
      if (clear || !enable) begin
        count <= {CNT_W{1'b0}};
      end else if (tick) begin
        if (count >= last_cnt) begin
          count  <= {CNT_W{1'b0}};
          expire <= 1'b1;
        end else begin
          count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // watchdog_counter

// ### verif/watchdog_timer_props.sv
// Port checker for the watchdog timer.
// Assumes a bind into watchdog_timer; a single clock domain.
`timescale 1ns/100ps
module watchdog_timer_props #(
  parameter BASE_CYCLES = 16,
  parameter OSC_DIV     = 2
) (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst_n,
  input wire        clk_en,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Core, fuse, result
  input wire        kick_instruction,
  input wire        chip_reset,
  input wire        always_on_fuse,
  input wire        dog_reset_pulse
);
  localparam int MINC = BASE_CYCLES * OSC_DIV - OSC_DIV;
  localparam int MAXC = BASE_CYCLES * 128 * OSC_DIV + 8;
  wire  rd_ctl = psel && penable && !pwrite && paddr == 12'h000;
  wire  wr_ctl = psel && penable && pwrite && clk_en && paddr == 12'h000;
  int   since_clear;
  int   since_ce;
  logic on_written;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_clear <= 0;
      since_ce    <= 99;
      on_written  <= 1'b0;
    end else begin
      since_clear <= (kick_instruction || chip_reset || dog_reset_pulse) ? 0 : since_clear + 1;
      since_ce    <= (wr_ctl && pwdata[4]) ? 0 : (since_ce < 99) ? since_ce + 1 : 99;
      on_written  <= (wr_ctl && pwdata[3]) || (on_written && !chip_reset && !dog_reset_pulse);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_pulse_single: assert property (dog_reset_pulse |=> !dog_reset_pulse)
    else $error("reset pulse longer than one cycle");
  a_no_early_pulse: assert property (dog_reset_pulse |-> since_clear >= MINC)
    else $error("reset pulse too soon after kick or clear");
  a_lvl2_cap: assert property (always_on_fuse |-> since_clear <= MAXC)
    else $error("always-on watchdog overran its longest period");
  a_off_until_on: assert property (dog_reset_pulse && !always_on_fuse |-> on_written)
    else $error("reset pulse without an enabling write");
  a_change_closes: assert property (rd_ctl && prdata[4] |-> since_ce <= 4)
    else $error("change bit still set too long");
  a_reserved_zero: assert property (rd_ctl |-> prdata[31:5] == 27'h0)
    else $error("reserved control bits not zero");
  a_lvl2_reads_on: assert property (rd_ctl && always_on_fuse |-> prdata[3])
    else $error("always-on enable bit read zero");
  a_unmapped_err: assert property (psel && penable && !pwrite && paddr[11:3] != 9'h0
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  c_pulse: cover property (dog_reset_pulse);
  c_window: cover property (rd_ctl && prdata[4]);
  c_chip: cover property (chip_reset);
endmodule // watchdog_timer_props
bind watchdog_timer watchdog_timer_props #(.BASE_CYCLES(BASE_CYCLES), .OSC_DIV(OSC_DIV)) props (
  .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .kick_instruction(kick_instruction), .chip_reset(chip_reset),
  .always_on_fuse(always_on_fuse), .dog_reset_pulse(dog_reset_pulse));

// ### verif/core_model.sv
// Processor core model: APB master and periodic or single kicks.
// Assumes tasks are called by the bench; all changes follow a rising edge.
`timescale 1ns/100ps
module core_model (
  // Clock and APB answer
  input  wire         ref_clk,
  input  wire         pready,
  input  wire  [31:0] prdata,
  input  wire         pslverr,
  // APB request and kick
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic        kick_instruction
);
  int   kick_per = 10;
  int   kcnt = 0;
  logic kick_now = 1'b0;
  initial begin
    {psel, penable, pwrite, paddr, pwdata, kick_instruction} = '0;
  end
  always @(posedge ref_clk) begin
    kcnt <= (kick_per == 0 || kcnt >= kick_per - 1) ? 0 : kcnt + 1;
    kick_instruction <= kick_now || (kick_per != 0 && kcnt == 0);
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic kick();
    @(posedge ref_clk);
    kick_now <= 1'b1;
    @(posedge ref_clk);
    kick_now <= 1'b0;
  endtask
endmodule // core_model

// ### verif/watchdog_timer_with_safety_levels_tb.sv
// Self-checking bench for the watchdog timer with safety levels.
// Assumes core_model as the APB master; short counts for speed.
`timescale 1ns/100ps
module watchdog_timer_with_safety_levels_tb;
  localparam int BASE = 16;
  localparam int DIV  = 2;
  logic        ref_clk, rst_n, chip_reset, always_on_fuse, compatibility_fuse, clk_en;
  wire         psel, penable, pwrite, pready, pslverr, kick_instruction, dog_reset_pulse;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  int          mismatches = 0, checks = 0, pulses = 0, cyc = 0;
  int          lvl, on, sel, s, n, p0, ex;
  logic [31:0] r;
  logic        e;
  watchdog_timer #(.BASE_CYCLES(BASE), .OSC_DIV(DIV)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .kick_instruction(kick_instruction), .chip_reset(chip_reset),
    .always_on_fuse(always_on_fuse), .compatibility_fuse(compatibility_fuse),
    .dog_reset_pulse(dog_reset_pulse));
  core_model core (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .kick_instruction(kick_instruction));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (dog_reset_pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function logic [31:0] ctl();
    return {28'h0, on[0], sel[2:0]};
  endfunction
  task rd(input logic [11:0] a, input logic [31:0] exp);
    core.xfer(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, r, e);
  endtask
  task open_set(input logic [31:0] v);
    wr(12'h000, 32'h18);
    wr(12'h000, v);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, chip_reset, always_on_fuse, compatibility_fuse} = 4'h0;
    clk_en = 1'b1;
    void'($urandom(32'hAD224F59));
    for (lvl = 0; lvl < 3; lvl++) begin
      @(posedge ref_clk);
      rst_n <= 1'b0;
      always_on_fuse <= (lvl == 2);
      compatibility_fuse <= (lvl == 0);
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      on = (lvl == 2);
      sel = 0;
      p0 = pulses;
      rd(12'h000, ctl());
      rd(12'h004, 32'h0);
      s = $urandom % 8;
      wr(12'h000, 32'hE8 | s);
      on = 1;
      if (lvl == 0) sel = s;
      rd(12'h000, ctl());
      wr(12'h000, 32'h18);
      if (lvl == 0) sel = 0;
      rd(12'h000, ctl() | 32'h10);
      repeat (6) @(posedge ref_clk);
      rd(12'h000, ctl());
      wr(12'h000, 32'h00);
      rd(12'h000, ctl());
      s = $urandom % 8;
      open_set(s);
      on = (lvl == 2);
      sel = s;
      rd(12'h000, ctl());
      check(pulses, p0);
      for (s = 0; s < 8; s++) begin
        open_set(32'h08 | s);
        core.kick_per = 0;
        core.kick();
        p0 = pulses;
        n = 0;
        while (pulses == p0 && n < 5000) begin
          @(posedge ref_clk);
          n++;
        end
        ex = (BASE << s) * DIV;
        check({31'h0, n >= ex - DIV && n <= ex + DIV + 6}, 32'h1);
        core.kick_per = 10;
        on = (lvl == 2);
        sel = 0;
        rd(12'h000, ctl());
        rd(12'h004, 32'h08);
        wr(12'h004, 32'h0);
        rd(12'h004, 32'h0);
      end
      wr(12'h000, 32'h08);
      core.kick_per = 0;
      core.kick();
      repeat (16) @(posedge ref_clk);
      chip_reset <= 1'b1;
      @(posedge ref_clk);
      chip_reset <= 1'b0;
      p0 = pulses;
      repeat (24) @(posedge ref_clk);
      check(pulses, p0);
      core.kick();
      rd(12'h000, ctl());
      wr(12'h000, 32'h08);
      core.kick();
      @(posedge ref_clk);
      clk_en <= 1'b0;
      p0 = pulses;
      repeat (60) @(posedge ref_clk);
      check(pulses, p0);
      clk_en <= 1'b1;
      core.kick();
      core.kick_per = 10;
      on = 1;
      rd(12'h000, ctl());
      core.xfer(1'b0, 12'h008, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
      check(r, 32'h0);
      $display("level %0d done", lvl);
    end
    print_verdict();
  end
endmodule // watchdog_timer_with_safety_levels_tb
